// ### hdl/sli_hold_if.sv
// Purpose: Start and busy pair between the indicator control and a hold timer
// Assumes: Single clock domain
// Notes:   start is a one-cycle pulse, busy a level
`timescale 1ns/1ps
`default_nettype none

interface sli_hold_if;
	logic start;	// Restart the hold
	logic busy;	// Hold still running

	modport ctrl (output start, input busy);
	modport tmr  (input start, output busy);
endinterface // sli_hold_if

`default_nettype wire

// ### hdl/sli_hold_timer.sv
// Purpose: Retriggerable hold timer of a fixed number of clock cycles
// Assumes: CYCLES of at least one
// Notes:   busy rises the edge after start and stays up CYCLES cycles after the last start
`timescale 1ns/1ps
`default_nettype none

module sli_hold_timer #(
	parameter int unsigned CYCLES = 1
) (
	input  wire logic clk,
	input  wire logic reset_n,
	sli_hold_if.tmr   hold
);

	logic [31:0] count;	// Cycles left after the current one

	// Each start reloads, so a new event restarts the hold
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			count     <= 32'h0000_0000;
			hold.busy <= 1'b0;
		end else if (hold.start) begin // RULE10
			count     <= 32'(CYCLES - 1);
			hold.busy <= 1'b1;
		end else if (hold.busy) begin
			// Expire once the count has run out
			if (count == 32'h0000_0000) begin
				hold.busy <= 1'b0;
			end else begin
				count <= count - 32'h0000_0001;
			end
		end
	end

endmodule // sli_hold_timer

`default_nettype wire

// ### hdl/sli_map.svh
// Purpose: Offsets, field positions, reset values and timing figures of the status indicator block
// Assumes: Included by bare name wherever the figures are needed
// Notes:   Definitions only
`ifndef SLI_MAP_SVH
`define SLI_MAP_SVH

// Register map
`define SLI_UNIT_POWER_SWITCH_OFS 12'h610
`define SLI_ADDR_W                12
`define SLI_PWR_BIT               31
`define SLI_UNIT_POWER_RESET      32'h0000_0000

// Timing figures as printed
`define SLI_CLK_HZ                50000000
`define SLI_BUS_RESET_MS          660
`define SLI_ACTIVITY_MS           500
`define SLI_FLASH_HZ              5

// Indicator intensities
`define SLI_LEVEL_OFF             8'h00
`define SLI_LEVEL_DULL            8'h30
`define SLI_LEVEL_BRIGHT          8'hc0
`define SLI_LEVEL_MAX             8'hff

`endif

// ### hdl/sli_pkg.sv
// Purpose: Types shared by the status indicator block
// Assumes: Nothing beyond the map header
// Notes:   Display states listed from highest precedence down
package sli_pkg;

	// Colour and intensity currently shown
	typedef enum logic [3:0] {
		SLI_SHOW_STARTUP,
		SLI_SHOW_BUS_RESET,
		SLI_SHOW_POWER_FAIL,
		SLI_SHOW_FW_FLASH,
		SLI_SHOW_CFG_DULL,
		SLI_SHOW_CFG_BRIGHT,
		SLI_SHOW_DOWN_DULL,
		SLI_SHOW_DOWN_BRIGHT,
		SLI_SHOW_IDLE,
		SLI_SHOW_ACTIVE
	} sli_show_type;

endpackage

// ### hdl/sli_status_led.sv
// Purpose: Two-colour status indicator control and unit power switch register
// Assumes: All inputs synchronous to clk; event inputs are one-cycle pulses
// Notes:   Intensities are 8-bit levels for an external PWM stage; yellow is red plus green
`timescale 1ns/1ps
`default_nettype none
`include "sli_map.svh"

// Notes on behaviour
// RULE1 - Max red from power-on until initialised
// RULE2 - Bus reset shows max red 0.66 s
// RULE3 - Power failure red until software powers up
// RULE4 - Idle dull green; activity bright green 0.5 s
// RULE5 - Powered down dull yellow; activity bright 0.5 s
// RULE6 - Firmware update flashes red/green at 5 Hz
// RULE7 - Power switch register; powered-down display follows it
// RULE8 - Power cycle restores defaults or saved channel
// RULE9 - Config error red; urgent states take precedence
// RULE10 - Holds and flash counted from clock frequency
module sli_status_led
	import sli_pkg::*;
#(
	parameter int unsigned CLK_HZ            = `SLI_CLK_HZ,
	parameter int unsigned BUS_RESET_CYCLES  = (CLK_HZ / 1000) * `SLI_BUS_RESET_MS,
	parameter int unsigned ACTIVITY_CYCLES   = (CLK_HZ / 1000) * `SLI_ACTIVITY_MS,
	parameter int unsigned FLASH_HALF_CYCLES = CLK_HZ / (2 * `SLI_FLASH_HZ)
) (
	input  wire logic                   clk,
	input  wire logic                   reset_n,
	input  wire logic                   init_done,
	input  wire logic                   bus_reset,
	input  wire logic                   power_fail,
	input  wire logic                   bus_activity,
	input  wire logic                   fw_update,
	input  wire logic                   config_error,
	input  wire logic                   config_error_bright,
	input  wire logic                   restore_valid,
	input  wire logic                   restore_power,
	input  wire logic [`SLI_ADDR_W-1:0] reg_addr,
	input  wire logic                   reg_wr_en,
	input  wire logic [31:0]            reg_wdata,
	output var  logic [31:0]            reg_rdata,
	output var  logic                   unit_powered,
	output var  logic [7:0]             led_red,
	output var  logic [7:0]             led_green
);

	logic         init_pending;	// Still in initial startup
	logic         fail_hold;	// Power failure awaiting power-up write
	logic         restore_done;	// Saved settings already applied
	logic [31:0]  flash_count;	// Cycles into the current flash half
	logic         flash_phase;	// Low shows red, high shows green
	sli_show_type next_show;	// Display chosen this cycle
	logic         pwr_wr;	// Write to the power switch register
	logic [7:0]   next_red;	// Red level for the chosen display
	logic [7:0]   next_green;	// Green level for the chosen display

	// Reset image of the power switch register, named so its power bit can be picked out
	// Power stays off after reset unless a saved channel says otherwise
	localparam logic [31:0] UNIT_POWER_RESET = `SLI_UNIT_POWER_RESET;

	sli_hold_if bus_hold ();	// Bus reset hold
	sli_hold_if act_hold ();	// Activity hold

	// Bus reset hold, 0.66 s
	sli_hold_timer #(
		.CYCLES (BUS_RESET_CYCLES)
	) u_bus_hold (
		.clk     (clk),
		.reset_n (reset_n),
		.hold    (bus_hold.tmr)
	);

	// Activity hold, 0.5 s, shared by green and yellow displays
	sli_hold_timer #(
		.CYCLES (ACTIVITY_CYCLES)
	) u_act_hold (
		.clk     (clk),
		.reset_n (reset_n),
		.hold    (act_hold.tmr)
	);

	assign bus_hold.start = bus_reset;	// RULE2
	assign act_hold.start = bus_activity;	// RULE4 RULE5
	assign pwr_wr = reg_wr_en && (reg_addr == `SLI_UNIT_POWER_SWITCH_OFS);

	// Startup flag, dropped once initialisation reports done
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			init_pending <= 1'b1; // RULE1
		end else if (init_done) begin
			init_pending <= 1'b0;
		end
	end

	// Power failure latch; a new failure wins over a same-cycle power-up
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			fail_hold <= 1'b0;
		end else if (power_fail) begin
			fail_hold <= 1'b1; // RULE3
		end else if (pwr_wr && reg_wdata[`SLI_PWR_BIT]) begin
			fail_hold <= 1'b0; // RULE3
		end
	end

	// Power switch register; defaults on reset, saved channel applied once after release
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			unit_powered <= UNIT_POWER_RESET[`SLI_PWR_BIT]; // RULE8
			restore_done <= 1'b0;
		end else if (pwr_wr) begin
			// Software write takes priority over the restore
			unit_powered <= reg_wdata[`SLI_PWR_BIT]; // RULE7
			restore_done <= 1'b1;
		end else if (!restore_done) begin
			// Strap-like level caught after release, never under reset
			restore_done <= 1'b1;
			if (restore_valid) begin
				unit_powered <= restore_power; // RULE8
			end
		end
	end

	// Register read-back; unmapped offsets read zero
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_addr == `SLI_UNIT_POWER_SWITCH_OFS) begin
			reg_rdata <= {unit_powered, 31'h0000_0000}; // RULE7
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	// Flash divider; starts in the red half whenever an update begins
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			flash_count <= 32'h0000_0000;
			flash_phase <= 1'b0;
		end else if (!fw_update) begin
			flash_count <= 32'h0000_0000;
			flash_phase <= 1'b0;
		end else if (flash_count == 32'(FLASH_HALF_CYCLES - 1)) begin
			flash_count <= 32'h0000_0000; // RULE6 RULE10
			flash_phase <= !flash_phase;
		end else begin
			flash_count <= flash_count + 32'h0000_0001;
		end
	end

	// Display selection, most urgent condition first
	always_comb begin
		if (init_pending) begin
			next_show = SLI_SHOW_STARTUP; // RULE1 RULE9
		end else if (bus_hold.busy) begin
			next_show = SLI_SHOW_BUS_RESET; // RULE2 RULE9
		end else if (fail_hold) begin
			next_show = SLI_SHOW_POWER_FAIL; // RULE3 RULE9
		end else if (fw_update) begin
			next_show = SLI_SHOW_FW_FLASH; // RULE6 RULE9
		end else if (config_error) begin
			next_show = config_error_bright ? SLI_SHOW_CFG_BRIGHT : SLI_SHOW_CFG_DULL; // RULE9
		end else if (!unit_powered) begin
			next_show = act_hold.busy ? SLI_SHOW_DOWN_BRIGHT : SLI_SHOW_DOWN_DULL; // RULE5 RULE7
		end else begin
			next_show = act_hold.busy ? SLI_SHOW_ACTIVE : SLI_SHOW_IDLE; // RULE4
		end
	end

	// Colour levels for the chosen display
	always_comb begin
		next_red   = `SLI_LEVEL_OFF;
		next_green = `SLI_LEVEL_OFF;
		case (next_show)
			SLI_SHOW_STARTUP, SLI_SHOW_BUS_RESET, SLI_SHOW_POWER_FAIL: begin
				next_red = `SLI_LEVEL_MAX;
			end
			SLI_SHOW_FW_FLASH: begin
				// Alternate colours, never both at once
				next_red   = flash_phase ? `SLI_LEVEL_OFF : `SLI_LEVEL_MAX;
				next_green = flash_phase ? `SLI_LEVEL_MAX : `SLI_LEVEL_OFF;
			end
			SLI_SHOW_CFG_DULL: begin
				next_red = `SLI_LEVEL_DULL;
			end
			SLI_SHOW_CFG_BRIGHT: begin
				next_red = `SLI_LEVEL_BRIGHT;
			end
			SLI_SHOW_DOWN_DULL: begin
				next_red   = `SLI_LEVEL_DULL;
				next_green = `SLI_LEVEL_DULL;
			end
			SLI_SHOW_DOWN_BRIGHT: begin
				next_red   = `SLI_LEVEL_BRIGHT;
				next_green = `SLI_LEVEL_BRIGHT;
			end
			SLI_SHOW_IDLE: begin
				next_green = `SLI_LEVEL_DULL;
			end
			SLI_SHOW_ACTIVE: begin
				next_green = `SLI_LEVEL_BRIGHT;
			end
			default: begin
				next_red = `SLI_LEVEL_MAX;
			end
		endcase
	end

	// Registered drive so the indicator never glitches
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			led_red   <= `SLI_LEVEL_MAX; // RULE1
			led_green <= `SLI_LEVEL_OFF;
		end else begin
			led_red   <= next_red;
			led_green <= next_green;
		end
	end

endmodule // sli_status_led

`default_nettype wire

// ### verif/sli_led_model.sv
// Purpose: Bicolour indicator seen from outside
// Assumes: Levels are PWM duties
// Notes:   Any nonzero duty lights a die
`timescale 1ns/1ps
`default_nettype none
module sli_led_model (
	input  wire logic [7:0] led_red,
	input  wire logic [7:0] led_green,
	output var  logic       lit_red,
	output var  logic       lit_green
);
	assign lit_red   = |led_red;	// Red die glows
	assign lit_green = |led_green;	// Green die glows
endmodule // sli_led_model
`default_nettype wire

// ### verif/sli_status_led_properties.sv
// Purpose: Port assertions for the status indicator
// Assumes: Holds shortened to 20/10/8 cycles
// Notes:   Bound to every instance of the top
`timescale 1ns/1ps
`default_nettype none
module sli_status_led_properties (
	input wire logic        clk, reset_n, init_done, bus_reset, power_fail, bus_activity,
	input wire logic        fw_update, config_error, config_error_bright, restore_valid, restore_power,
	input wire logic [11:0] reg_addr,
	input wire logic        reg_wr_en, unit_powered,
	input wire logic [31:0] reg_wdata, reg_rdata,
	input wire logic [7:0]  led_red, led_green
);
	logic       seen;	// Init has been seen
	logic       pf;	// Power fail pending
	logic [4:0] quiet;	// Cycles with no event
	logic       pon;	// Power-on write
	assign pon = reg_wr_en && reg_addr == 12'h610 && reg_wdata[31];
	// Track startup, pending failure and quiet time
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			seen <= 1'b0;
			pf <= 1'b0;
			quiet <= 5'h0;
		end else begin
			seen <= seen | init_done;
			pf <= power_fail | (pf & !pon);
			if (bus_reset | bus_activity | power_fail | reg_wr_en | fw_update | config_error | !seen)
				quiet <= 5'h0;
			else if (quiet != 5'h1f)
				quiet <= quiet + 5'h1;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	startup_red_a: assert property (!seen |-> led_red == 8'hff && led_green == 8'h00)
		else $error("startup colour wrong");
	bus_reset_a: assert property (bus_reset && seen |-> ##2 (led_red == 8'hff && led_green == 8'h00)[*8])
		else $error("bus reset hold wrong");
	fail_hold_a: assert property (pf && $past(pf) |-> led_red == 8'hff && led_green == 8'h00)
		else $error("power fail colour wrong");
	idle_dull_a: assert property (quiet == 5'h1f && !pf |-> led_green == 8'h30
		&& led_red == (unit_powered ? 8'h00 : 8'h30)) else $error("idle colour wrong");
	act_bright_a: assert property (bus_activity && quiet == 5'h1f && !pf |-> ##2 (led_green == 8'hc0)[*8])
		else $error("activity hold wrong");
	flash_apart_a: assert property (fw_update[*3] |-> !(led_red != 8'h00 && led_green != 8'h00))
		else $error("flash shows both");
	switch_wr_a: assert property (reg_wr_en && reg_addr == 12'h610 |=> unit_powered == $past(reg_wdata[31]))
		else $error("power switch write lost");
	read_back_a: assert property (reg_rdata ==
		($past(reg_addr) == 12'h610 ? {$past(unit_powered), 31'h0} : 32'h0)) else $error("read data wrong");
	cover property (bus_reset && seen);
	cover property (fw_update && led_red == 8'h00 && led_green == 8'hff);
	cover property (bus_activity && !unit_powered);
	cover property (pf && pon);
endmodule // sli_status_led_properties
bind sli_status_led sli_status_led_properties u_sli_status_led_properties (.*);
`default_nettype wire

// ### verif/tb.sv
// Purpose: Self-checking bench for the status indicator
// Assumes: Holds shortened to 20/10/8 cycles
// Notes:   Inputs move 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        clk = 0, reset_n = 0, init_done = 0, bus_reset = 0, power_fail = 0, bus_activity = 0;
	logic        fw_update = 0, config_error = 0, config_error_bright = 0, restore_valid = 0, restore_power = 0;
	logic        reg_wr_en = 0, unit_powered, lit_red, lit_green;
	logic [11:0] reg_addr = 12'h610;
	logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata;
	logic [7:0]  led_red, led_green;
	int          fail_count = 0, checked = 0, n;
	always #10 clk = ~clk;
	sli_status_led #(.BUS_RESET_CYCLES(20), .ACTIVITY_CYCLES(10), .FLASH_HALF_CYCLES(8)) u_sli_status_led (.*);
	sli_led_model u_sli_led_model (.*);
	task automatic step(input int c); repeat (c) @(posedge clk); #1; endtask
	task automatic check(input logic [31:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic led(input logic [7:0] r, g); check({led_red, led_green}, {r, g}); endtask
	task automatic pulse(ref logic s); s = 1; step(1); s = 0; endtask
	task automatic wr(input logic [31:0] d); reg_wdata = d; reg_wr_en = 1; step(1); reg_wr_en = 0; endtask
	task automatic do_reset; reset_n = 0; step(3); reset_n = 1; endtask
	task automatic wait_for(ref logic s); n = 0; while (s !== 1 && n < 40) begin step(1); n++; end endtask
	task automatic tally_and_finish;
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic t_start;
		step(5);
		led(8'hff, 8'h00);
		check(unit_powered, 0);
		check(reg_rdata, 32'h0000_0000);
		pulse(init_done);
		step(3);
		led(8'h30, 8'h30);
		$display("startup done");
	endtask
	task automatic t_bus;
		pulse(bus_reset);
		step(2);
		led(8'hff, 8'h00);
		step(16);
		led(8'hff, 8'h00);
		step(14);
		led(8'h30, 8'h30);
		$display("bus reset done");
	endtask
	task automatic t_act;
		pulse(bus_activity);
		step(2);
		led(8'hc0, 8'hc0);
		step(12);
		led(8'h30, 8'h30);
		wr(32'h8000_0000);
		check(unit_powered, 1);
		step(1);
		check(reg_rdata, 32'h8000_0000);
		step(1);
		led(8'h00, 8'h30);
		pulse(bus_activity);
		step(5);
		pulse(bus_activity);
		step(9);
		led(8'h00, 8'hc0);
		step(4);
		led(8'h00, 8'h30);
		$display("activity done");
	endtask
	task automatic t_fail;
		pulse(power_fail);
		step(25);
		led(8'hff, 8'h00);
		reg_addr = 12'h614;
		wr(32'h8000_0000);
		check(reg_rdata, 32'h0000_0000);
		step(3);
		led(8'hff, 8'h00);
		reg_addr = 12'h610;
		wr(32'h8000_0000);
		step(2);
		led(8'h00, 8'h30);
		$display("power fail done");
	endtask
	task automatic t_flash;
		fw_update = 1;
		wait_for(lit_green);
		wait_for(lit_red);
		n = 0;
		while (lit_red && n < 40) begin check(lit_green, 0); step(1); n++; end
		check(n, 8);
		n = 0;
		while (lit_green && n < 40) begin check(lit_red, 0); step(1); n++; end
		check(n, 8);
		fw_update = 0;
		$display("flash done");
	endtask
	task automatic t_cfg;
		config_error = 1;
		step(2);
		led(8'h30, 8'h00);
		config_error_bright = 1;
		step(2);
		led(8'hc0, 8'h00);
		fw_update = 1;
		wait_for(lit_green);
		check(lit_green, 1);
		fw_update = 0;
		config_error = 0;
		$display("config error done");
	endtask
	task automatic t_restore;
		restore_valid = 1;
		restore_power = 1;
		do_reset;
		step(2);
		check(unit_powered, 1);
		restore_valid = 0;
		do_reset;
		step(2);
		check(unit_powered, 0);
		led(8'hff, 8'h00);
		$display("restore done");
	endtask
	initial begin #20us; fail_count++; tally_and_finish; end
	initial begin
		do_reset;
		t_start;
		t_bus;
		t_act;
		t_fail;
		t_flash;
		t_cfg;
		t_restore;
		tally_and_finish;
	end
endmodule // tb
`default_nettype wire
